// *** power_mode_lvd_pkg.sv ***
package power_mode_lvd_pkg;

  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] CTRL1_INDEX = 16'h3040;
  localparam logic [ADDR_W-1:0] CTRL2_INDEX = 16'h3041;
  localparam logic [ADDR_W-1:0] CTRL1_ADDR = {CTRL1_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] CTRL2_ADDR = {CTRL2_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] DEBUG_ADDR = 16'h3048;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 16'h304c;
  localparam logic [ADDR_W-1:0] RESET_STATUS_ADDR = 16'h3050;

  localparam logic [7:0] CTRL1_RESET = 8'h1c;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  localparam int WARN_FLAG_BIT = 7;
  localparam int WARN_ACK_BIT = 6;
  localparam int WARN_IRQ_EN_BIT = 5;
  localparam int RESET_EN_BIT = 4;
  localparam int DETECT_IN_STOP_BIT = 3;
  localparam int DETECTOR_EN_BIT = 2;

  localparam int TRIP_SELECT_BIT = 0;
  localparam int WARN_TRIP_LSB = 1;
  localparam int WARN_TRIP_W = 2;

  localparam int DEBUG_ENTRY_BIT = 0;
  localparam int STATUS_POR_BIT = 1;
  localparam int STATUS_LOWV_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    MODE_RUN = 4'b0001,
    MODE_WAIT = 4'b0010,
    MODE_STOP = 4'b0100,
    MODE_DEBUG = 4'b1000
  } power_mode_t;

  typedef enum logic [2:0] {
    DBG_STATUS_OK = 3'b001,
    DBG_STATUS_LOWPOWER = 3'b010,
    DBG_STATUS_IDLE = 3'b100
  } debug_status_t;

  typedef struct packed {
    logic regulatorFull;
    logic regulatorLoose;
    logic cpuClockOn;
    logic ramOn;
    logic peripheralsOn;
    logic debugClockOn;
    logic detectorOn;
    logic pinsHeld;
    logic lowPowerOscOn;
    logic optionalOn;
  } power_domains_t;

  typedef struct packed {
    logic porLevel;
    logic detectLow;
    logic detectHigh;
    logic [3:0] warnLevel;
  } supply_levels_t;

  typedef struct packed {
    logic waitInstr;
    logic stopInstr;
    logic wakeInterrupt;
  } cpu_request_t;

  typedef struct packed {
    logic haltCmd;
    logic memStatusCmd;
    logic otherCmd;
  } debug_request_t;

endpackage

// *** power_mode_lvd_control.sv ***
`timescale 1ns/1ns
module power_mode_lvd_control #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire power_mode_lvd_pkg::cpu_request_t cpuReq,
  input wire power_mode_lvd_pkg::debug_request_t debugReq,
  input wire power_mode_lvd_pkg::supply_levels_t supplyRaw,
  output logic clearIntMask,
  output power_mode_lvd_pkg::debug_status_t debugStatus,
  output logic debugMemGrant,
  output power_mode_lvd_pkg::power_domains_t domains,
  output power_mode_lvd_pkg::power_mode_t powerMode,
  output logic systemResetHold,
  output logic warningIrq
);

  if (ADDR_WIDTH != power_mode_lvd_pkg::ADDR_W) begin
    $error("ADDR_WIDTH must match package address width");
  end

  localparam int SUPPLY_W = $bits(power_mode_lvd_pkg::supply_levels_t);

  logic [SUPPLY_W-1:0] supplyMeta_reg;
  logic [SUPPLY_W-1:0] supplySync_reg;
  power_mode_lvd_pkg::supply_levels_t supply;

  logic warnFlag_reg;
  logic warnIrqEn_reg;
  logic resetEn_reg;
  logic detectInStop_reg;
  logic detectorEn_reg;
  logic ctrl1Bit1_reg;
  logic ctrl1Bit0_reg;
  logic resetEnWritten_reg;
  logic detectorEnWritten_reg;
  logic tripSelect_reg;
  logic [power_mode_lvd_pkg::WARN_TRIP_W-1:0] warnTrip_reg;
  logic debugEntry_reg;
  logic porFlag_reg;
  logic lowvFlag_reg;
  logic lowvHold_reg;
  logic keepDetectInStop_reg;
  logic keepDebugInStop_reg;

  power_mode_lvd_pkg::power_mode_t mode_reg;
  power_mode_lvd_pkg::power_mode_t mode_next;

  logic [ADDR_WIDTH-1:0] awAddr_reg;
  logic awHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic wHeld_reg;
  logic doWrite;
  logic [ADDR_WIDTH-1:0] wrAddr;
  logic [31:0] wrData;
  logic wrLane0;

  logic detectorActive;
  logic belowTrip;
  logic warnCondition;
  logic lowvResetEvent;
  logic writeCtrl1;
  logic writeCtrl2;
  logic writeDebug;

  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
    isMapped = (addr == power_mode_lvd_pkg::CTRL1_ADDR) || (addr == power_mode_lvd_pkg::CTRL2_ADDR) ||
               (addr == power_mode_lvd_pkg::DEBUG_ADDR) || (addr == power_mode_lvd_pkg::MODE_ADDR) ||
               (addr == power_mode_lvd_pkg::RESET_STATUS_ADDR);
  endfunction

  // Two-stage synchroniser on comparator outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      supplyMeta_reg <= '0;
      supplySync_reg <= '0;
    end else begin
      supplyMeta_reg <= supplyRaw;
      supplySync_reg <= supplyMeta_reg;
    end
  end

  assign supply = supplySync_reg;

  // Detector gated by enable and, in stop, by keep condition
  assign detectorActive = detectorEn_reg && ((mode_reg != power_mode_lvd_pkg::MODE_STOP) ||
                          keepDetectInStop_reg || keepDebugInStop_reg);
  assign belowTrip = tripSelect_reg ? supply.detectHigh : supply.detectLow;
  assign warnCondition = detectorActive && supply.warnLevel[warnTrip_reg];
  assign lowvResetEvent = detectorActive && resetEn_reg && belowTrip;

  // Reset hold: power-on until above low level; detect reset until above selected level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowvHold_reg <= 1'b1;
    end else if (supply.porLevel) begin
      lowvHold_reg <= 1'b1;
    end else if (lowvResetEvent) begin
      lowvHold_reg <= 1'b1;
    end else if (lowvHold_reg && !(porFlag_reg ? supply.detectLow : belowTrip)) begin
      lowvHold_reg <= 1'b0;
    end
  end

  assign systemResetHold = lowvHold_reg || supply.porLevel;

  // Reset status flags survive the detect reset they report
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      porFlag_reg <= 1'b1;
      lowvFlag_reg <= 1'b1;
    end else if (supply.porLevel) begin
      porFlag_reg <= 1'b1;
      lowvFlag_reg <= 1'b1;
    end else if (lowvResetEvent) begin
      porFlag_reg <= 1'b0;
      lowvFlag_reg <= 1'b1;
    end
  end

  // Write channel capture, address and data in either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_reg <= '0;
      awHeld_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awAddr_reg <= s_axi_awaddr;
      awHeld_reg <= 1'b1;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wData_reg <= '0;
      wStrb_reg <= '0;
      wHeld_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
      wHeld_reg <= 1'b1;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign wrAddr = awAddr_reg;
  assign wrData = wData_reg;
  assign wrLane0 = wStrb_reg[0];
  assign writeCtrl1 = doWrite && wrLane0 && (wrAddr == power_mode_lvd_pkg::CTRL1_ADDR);
  assign writeCtrl2 = doWrite && wrLane0 && (wrAddr == power_mode_lvd_pkg::CTRL2_ADDR);
  assign writeDebug = doWrite && wrLane0 && (wrAddr == power_mode_lvd_pkg::DEBUG_ADDR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= power_mode_lvd_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(wrAddr) ? power_mode_lvd_pkg::RESP_OKAY : power_mode_lvd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      warnIrqEn_reg <= power_mode_lvd_pkg::CTRL1_RESET[power_mode_lvd_pkg::WARN_IRQ_EN_BIT];
      resetEn_reg <= power_mode_lvd_pkg::CTRL1_RESET[power_mode_lvd_pkg::RESET_EN_BIT];
      detectInStop_reg <= power_mode_lvd_pkg::CTRL1_RESET[power_mode_lvd_pkg::DETECT_IN_STOP_BIT];
      detectorEn_reg <= power_mode_lvd_pkg::CTRL1_RESET[power_mode_lvd_pkg::DETECTOR_EN_BIT];
      ctrl1Bit1_reg <= power_mode_lvd_pkg::CTRL1_RESET[1];
      ctrl1Bit0_reg <= power_mode_lvd_pkg::CTRL1_RESET[0];
      resetEnWritten_reg <= 1'b0;
      detectorEnWritten_reg <= 1'b0;
    end else if (writeCtrl1) begin
      warnIrqEn_reg <= wrData[power_mode_lvd_pkg::WARN_IRQ_EN_BIT];
      detectInStop_reg <= wrData[power_mode_lvd_pkg::DETECT_IN_STOP_BIT];
      ctrl1Bit1_reg <= wrData[1];
      ctrl1Bit0_reg <= wrData[0];
      resetEnWritten_reg <= 1'b1;
      detectorEnWritten_reg <= 1'b1;
      if (!resetEnWritten_reg) begin
        resetEn_reg <= wrData[power_mode_lvd_pkg::RESET_EN_BIT];
      end
      if (!detectorEnWritten_reg) begin
        detectorEn_reg <= wrData[power_mode_lvd_pkg::DETECTOR_EN_BIT];
      end
    end
  end

  // Warning flag: set wins over acknowledge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      warnFlag_reg <= 1'b0;
    end else if (warnCondition) begin
      warnFlag_reg <= 1'b1;
    end else if (writeCtrl1 && wrData[power_mode_lvd_pkg::WARN_ACK_BIT]) begin
      warnFlag_reg <= 1'b0;
    end
  end

  assign warningIrq = warnFlag_reg && warnIrqEn_reg && detectorEn_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripSelect_reg <= power_mode_lvd_pkg::CTRL2_RESET[power_mode_lvd_pkg::TRIP_SELECT_BIT];
      warnTrip_reg <= power_mode_lvd_pkg::CTRL2_RESET[power_mode_lvd_pkg::WARN_TRIP_LSB +: power_mode_lvd_pkg::WARN_TRIP_W];
    end else if (writeCtrl2) begin
      tripSelect_reg <= wrData[power_mode_lvd_pkg::TRIP_SELECT_BIT];
      warnTrip_reg <= wrData[power_mode_lvd_pkg::WARN_TRIP_LSB +: power_mode_lvd_pkg::WARN_TRIP_W];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debugEntry_reg <= 1'b0;
    end else if (writeDebug) begin
      debugEntry_reg <= wrData[power_mode_lvd_pkg::DEBUG_ENTRY_BIT];
    end
  end

  // Read channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= power_mode_lvd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(s_axi_araddr) ? power_mode_lvd_pkg::RESP_OKAY : power_mode_lvd_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        power_mode_lvd_pkg::CTRL1_ADDR: begin
          s_axi_rdata <= {24'h000000, warnFlag_reg, 1'b0, warnIrqEn_reg, resetEn_reg, detectInStop_reg,
                          detectorEn_reg, ctrl1Bit1_reg, ctrl1Bit0_reg};
        end
        power_mode_lvd_pkg::CTRL2_ADDR: begin
          s_axi_rdata <= {29'h0, warnTrip_reg, tripSelect_reg};
        end
        power_mode_lvd_pkg::DEBUG_ADDR: begin
          s_axi_rdata <= {31'h0, debugEntry_reg};
        end
        power_mode_lvd_pkg::MODE_ADDR: begin
          s_axi_rdata <= {28'h0000000, mode_reg};
        end
        power_mode_lvd_pkg::RESET_STATUS_ADDR: begin
          s_axi_rdata <= {30'h0, porFlag_reg, lowvFlag_reg};
        end
        default: begin
          s_axi_rdata <= '0;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Power mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      power_mode_lvd_pkg::MODE_RUN: begin
        if (debugReq.haltCmd && debugEntry_reg) begin
          mode_next = power_mode_lvd_pkg::MODE_DEBUG;
        end else if (cpuReq.stopInstr) begin
          mode_next = power_mode_lvd_pkg::MODE_STOP;
        end else if (cpuReq.waitInstr) begin
          mode_next = power_mode_lvd_pkg::MODE_WAIT;
        end
      end
      power_mode_lvd_pkg::MODE_WAIT: begin
        if (debugReq.haltCmd) begin
          mode_next = power_mode_lvd_pkg::MODE_DEBUG;
        end else if (cpuReq.wakeInterrupt) begin
          mode_next = power_mode_lvd_pkg::MODE_RUN;
        end
      end
      power_mode_lvd_pkg::MODE_STOP: begin
        if (debugReq.haltCmd && debugEntry_reg) begin
          mode_next = power_mode_lvd_pkg::MODE_DEBUG;
        end else if (cpuReq.wakeInterrupt) begin
          mode_next = power_mode_lvd_pkg::MODE_RUN;
        end
      end
      power_mode_lvd_pkg::MODE_DEBUG: begin
        mode_next = power_mode_lvd_pkg::MODE_DEBUG;
      end
      default: begin
        mode_next = power_mode_lvd_pkg::MODE_RUN;
      end
    endcase
  end

  // Detect reset restarts the core in run mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= power_mode_lvd_pkg::MODE_RUN;
    end else if (systemResetHold) begin
      mode_reg <= power_mode_lvd_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Stop-entry options latched at the stop instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      keepDetectInStop_reg <= 1'b0;
      keepDebugInStop_reg <= 1'b0;
    end else if (mode_reg == power_mode_lvd_pkg::MODE_RUN && mode_next == power_mode_lvd_pkg::MODE_STOP) begin
      keepDetectInStop_reg <= detectorEn_reg && detectInStop_reg;
      keepDebugInStop_reg <= debugEntry_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clearIntMask <= 1'b0;
    end else begin
      clearIntMask <= mode_reg == power_mode_lvd_pkg::MODE_RUN && !systemResetHold &&
                      (mode_next == power_mode_lvd_pkg::MODE_WAIT || mode_next == power_mode_lvd_pkg::MODE_STOP);
    end
  end

  // Debug command filter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debugStatus <= power_mode_lvd_pkg::DBG_STATUS_IDLE;
      debugMemGrant <= 1'b0;
    end else if (debugReq.memStatusCmd || debugReq.otherCmd) begin
      if (mode_reg == power_mode_lvd_pkg::MODE_WAIT || mode_reg == power_mode_lvd_pkg::MODE_STOP) begin
        debugStatus <= power_mode_lvd_pkg::DBG_STATUS_LOWPOWER;
        debugMemGrant <= 1'b0;
      end else begin
        debugStatus <= power_mode_lvd_pkg::DBG_STATUS_OK;
        debugMemGrant <= debugReq.memStatusCmd;
      end
    end else begin
      debugStatus <= power_mode_lvd_pkg::DBG_STATUS_IDLE;
      debugMemGrant <= 1'b0;
    end
  end

  // Per-domain power state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      domains <= '0;
      powerMode <= power_mode_lvd_pkg::MODE_RUN;
    end else begin
      powerMode <= mode_reg;
      domains.lowPowerOscOn <= 1'b1;
      case (mode_reg)
        power_mode_lvd_pkg::MODE_WAIT: begin
          domains.regulatorFull <= 1'b1;
          domains.regulatorLoose <= 1'b0;
          domains.cpuClockOn <= 1'b0;
          domains.ramOn <= 1'b0;
          domains.peripheralsOn <= 1'b1;
          domains.debugClockOn <= 1'b1;
          domains.detectorOn <= detectorActive;
          domains.pinsHeld <= 1'b0;
          domains.optionalOn <= 1'b1;
        end
        power_mode_lvd_pkg::MODE_STOP: begin
          domains.regulatorFull <= keepDebugInStop_reg || keepDetectInStop_reg;
          domains.regulatorLoose <= !(keepDebugInStop_reg || keepDetectInStop_reg);
          domains.cpuClockOn <= 1'b0;
          domains.ramOn <= 1'b0;
          domains.peripheralsOn <= 1'b0;
          domains.debugClockOn <= keepDebugInStop_reg;
          domains.detectorOn <= detectorActive;
          domains.pinsHeld <= 1'b1;
          domains.optionalOn <= 1'b0;
        end
        default: begin
          domains.regulatorFull <= 1'b1;
          domains.regulatorLoose <= 1'b0;
          domains.cpuClockOn <= mode_reg != power_mode_lvd_pkg::MODE_DEBUG;
          domains.ramOn <= 1'b1;
          domains.peripheralsOn <= 1'b1;
          domains.debugClockOn <= 1'b1;
          domains.detectorOn <= detectorActive;
          domains.pinsHeld <= 1'b0;
          domains.optionalOn <= 1'b1;
        end
      endcase
    end
  end

endmodule

// *** power_mode_lvd_sva.sv ***
`timescale 1ns/1ns
module power_mode_lvd_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire power_mode_lvd_pkg::debug_request_t debugReq,
  input wire power_mode_lvd_pkg::supply_levels_t supplyRaw,
  input wire logic clearIntMask,
  input wire power_mode_lvd_pkg::debug_status_t debugStatus,
  input wire logic debugMemGrant,
  input wire power_mode_lvd_pkg::power_domains_t domains,
  input wire power_mode_lvd_pkg::power_mode_t powerMode,
  input wire logic systemResetHold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  write_resp_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_resp_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  mask_pulse_a: assert property (clearIntMask |=> powerMode inside {power_mode_lvd_pkg::MODE_WAIT,
    power_mode_lvd_pkg::MODE_STOP}) else $error("mask clear without low-power entry");
  mask_entry_a: assert property ((powerMode == power_mode_lvd_pkg::MODE_RUN) ##1 (powerMode inside
    {power_mode_lvd_pkg::MODE_WAIT, power_mode_lvd_pkg::MODE_STOP}) |-> $past(clearIntMask))
    else $error("low-power entry without mask clear");
  wait_domains_a: assert property (powerMode == power_mode_lvd_pkg::MODE_WAIT |->
    !domains.cpuClockOn && !domains.ramOn && domains.regulatorFull && domains.peripheralsOn && domains.debugClockOn)
    else $error("wait domains wrong");
  stop_domains_a: assert property (powerMode == power_mode_lvd_pkg::MODE_STOP |->
    !domains.cpuClockOn && !domains.ramOn && !domains.peripheralsOn && domains.pinsHeld && domains.lowPowerOscOn)
    else $error("stop domains wrong");
  run_domains_a: assert property ($past(rst_n) && powerMode == power_mode_lvd_pkg::MODE_RUN |->
    domains.cpuClockOn && domains.ramOn && domains.regulatorFull && !domains.pinsHeld)
    else $error("run domains wrong");
  lowpower_cmd_a: assert property (debugReq.memStatusCmd ##1 (powerMode inside {power_mode_lvd_pkg::MODE_WAIT,
    power_mode_lvd_pkg::MODE_STOP}) |-> debugStatus == power_mode_lvd_pkg::DBG_STATUS_LOWPOWER && !debugMemGrant)
    else $error("memory command not refused in low power");
  debug_cmd_a: assert property (debugReq.memStatusCmd ##1 powerMode == power_mode_lvd_pkg::MODE_DEBUG |->
    debugStatus == power_mode_lvd_pkg::DBG_STATUS_OK && debugMemGrant) else $error("debug mode refused command");
  por_hold_a: assert property (supplyRaw.porLevel [*4] |-> systemResetHold)
    else $error("power-on level not holding reset");
  hold_run_a: assert property (systemResetHold [*3] |-> powerMode == power_mode_lvd_pkg::MODE_RUN)
    else $error("mode not run while reset held");
endmodule
bind power_mode_lvd_control power_mode_lvd_checker power_mode_lvd_checker_inst (
  .clock(clock), .rst_n(rst_n), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .debugReq(debugReq), .supplyRaw(supplyRaw), .clearIntMask(clearIntMask),
  .debugStatus(debugStatus), .debugMemGrant(debugMemGrant), .domains(domains), .powerMode(powerMode),
  .systemResetHold(systemResetHold)
);

// *** cpu_debug_model.sv ***
`timescale 1ns/1ns
module cpu_debug_model (
  input wire logic clock,
  output power_mode_lvd_pkg::cpu_request_t cpuReq,
  output power_mode_lvd_pkg::debug_request_t debugReq
);
  initial begin
    cpuReq = '0;
    debugReq = '0;
  end
  // Instruction or debug command, one cycle wide
  task automatic issue(input logic [5:0] cmd);
    @(posedge clock);
    {cpuReq, debugReq} <= cmd;
    @(posedge clock);
    {cpuReq, debugReq} <= 6'h00;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  localparam logic [5:0] WAITI = 6'h20;
  localparam logic [5:0] STOPI = 6'h10;
  localparam logic [5:0] WAKE = 6'h08;
  localparam logic [5:0] HALT = 6'h04;
  localparam logic [5:0] MEMC = 6'h02;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  power_mode_lvd_pkg::cpu_request_t cpuReq;
  power_mode_lvd_pkg::debug_request_t debugReq;
  power_mode_lvd_pkg::supply_levels_t supplyRaw = 7'h00;
  power_mode_lvd_pkg::debug_status_t debugStatus;
  power_mode_lvd_pkg::power_domains_t domains;
  power_mode_lvd_pkg::power_mode_t powerMode;
  logic clearIntMask, debugMemGrant, systemResetHold, warningIrq;
  logic [31:0] rd;
  logic [1:0] rsp;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  always #20 clock = ~clock;
  cpu_debug_model cpu_debug_model_inst (.clock(clock), .cpuReq(cpuReq), .debugReq(debugReq));
  power_mode_lvd_control power_mode_lvd_control_inst (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpuReq(cpuReq), .debugReq(debugReq), .supplyRaw(supplyRaw), .clearIntMask(clearIntMask),
    .debugStatus(debugStatus), .debugMemGrant(debugMemGrant), .domains(domains), .powerMode(powerMode),
    .systemResetHold(systemResetHold), .warningIrq(warningIrq)
  );
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bchk(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic mchk(input logic [3:0] exp);
    chk("power mode", {28'h0, exp}, {28'h0, powerMode});
  endtask
  task automatic axi_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clock);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h000000, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [15:0] addr);
    @(posedge clock);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        break;
      end
    end
  endtask
  task automatic rchk(input string what, input logic [15:0] addr, input logic [31:0] exp);
    axi_read(addr);
    chk(what, exp, rd);
  endtask
  // Comparator change, then sync and flag update
  task automatic supply(input logic [6:0] lv);
    @(posedge clock);
    supplyRaw <= lv;
    repeat (4) @(posedge clock);
  endtask
  task automatic cmd(input logic [5:0] c);
    cpu_debug_model_inst.issue(c);
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic mem(input logic [2:0] st, input logic g);
    cpu_debug_model_inst.issue(MEMC);
    #1;
    chk("debug status", {29'h0, st}, {29'h0, debugStatus});
    bchk("memory grant", g, debugMemGrant);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    bchk("reset hold", 1'b0, systemResetHold);
    rchk("ctrl1 reset", power_mode_lvd_pkg::CTRL1_ADDR, 32'h1c);
    rchk("ctrl2 reset", power_mode_lvd_pkg::CTRL2_ADDR, 32'h00);
    rchk("reset status", power_mode_lvd_pkg::RESET_STATUS_ADDR, 32'h03);
    axi_read(16'h3044);
    chk("unmapped resp", {30'h0, power_mode_lvd_pkg::RESP_SLVERR}, {30'h0, rsp});
    axi_write(power_mode_lvd_pkg::CTRL1_ADDR, 8'h24);
    chk("write resp", {30'h0, power_mode_lvd_pkg::RESP_OKAY}, {30'h0, rsp});
    axi_write(power_mode_lvd_pkg::CTRL1_ADDR, 8'h33);
    rchk("ctrl1 second write", power_mode_lvd_pkg::CTRL1_ADDR, 32'h27);
    axi_write(power_mode_lvd_pkg::CTRL2_ADDR, 8'h04);
    supply(7'h0b);
    rchk("other warn levels", power_mode_lvd_pkg::CTRL1_ADDR, 32'h27);
    supply(7'h04);
    rchk("warn flag", power_mode_lvd_pkg::CTRL1_ADDR, 32'ha7);
    bchk("warn irq", 1'b1, warningIrq);
    axi_write(power_mode_lvd_pkg::CTRL1_ADDR, 8'h67);
    rchk("ack while low", power_mode_lvd_pkg::CTRL1_ADDR, 32'ha7);
    supply(7'h00);
    rchk("flag latched", power_mode_lvd_pkg::CTRL1_ADDR, 32'ha7);
    axi_write(power_mode_lvd_pkg::CTRL1_ADDR, 8'h67);
    rchk("ack cleared", power_mode_lvd_pkg::CTRL1_ADDR, 32'h27);
    bchk("irq cleared", 1'b0, warningIrq);
    cmd(WAITI);
    mchk(power_mode_lvd_pkg::MODE_WAIT);
    mem(power_mode_lvd_pkg::DBG_STATUS_LOWPOWER, 1'b0);
    cmd(WAKE);
    cmd(HALT);
    mchk(power_mode_lvd_pkg::MODE_RUN);
    cmd(STOPI);
    mchk(power_mode_lvd_pkg::MODE_STOP);
    bchk("stop detector off", 1'b0, domains.detectorOn);
    bchk("stop loose reg", 1'b1, domains.regulatorLoose);
    bchk("stop debug clock", 1'b0, domains.debugClockOn);
    mem(power_mode_lvd_pkg::DBG_STATUS_LOWPOWER, 1'b0);
    cmd(HALT);
    mchk(power_mode_lvd_pkg::MODE_STOP);
    cmd(WAKE);
    axi_write(power_mode_lvd_pkg::CTRL1_ADDR, 8'h2f);
    cmd(STOPI);
    bchk("stop detector on", 1'b1, domains.detectorOn);
    bchk("stop full reg", 1'b1, domains.regulatorFull);
    cmd(WAKE);
    axi_write(power_mode_lvd_pkg::DEBUG_ADDR, 8'h01);
    cmd(STOPI);
    bchk("debug clock kept", 1'b1, domains.debugClockOn);
    bchk("debug full reg", 1'b1, domains.regulatorFull);
    cmd(HALT);
    mchk(power_mode_lvd_pkg::MODE_DEBUG);
    mem(power_mode_lvd_pkg::DBG_STATUS_OK, 1'b1);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    mchk(power_mode_lvd_pkg::MODE_RUN);
    supply(7'h10);
    bchk("high level ignored", 1'b0, systemResetHold);
    axi_write(power_mode_lvd_pkg::CTRL2_ADDR, 8'h01);
    repeat (4) @(posedge clock);
    bchk("detect reset", 1'b1, systemResetHold);
    supply(7'h00);
    bchk("detect release", 1'b0, systemResetHold);
    rchk("detect status", power_mode_lvd_pkg::RESET_STATUS_ADDR, 32'h01);
    supply(7'h40);
    bchk("power-on hold", 1'b1, systemResetHold);
    supply(7'h00);
    bchk("power-on release", 1'b0, systemResetHold);
    rchk("power-on status", power_mode_lvd_pkg::RESET_STATUS_ADDR, 32'h03);
    conclude();
  end
endmodule
